//--- shared/mpd_pkg.sv
// Package for the meter PWM driver: register indices, field positions,
// reset values and state codes.
// Assumes a plain synchronous register port with 8-bit data.
//
// Behaviour
// - One 8-bit counter is the shared timebase.
// - Counter cleared by reset or run bit zero.
// - Starts at 00H, then cycles 01H to FFH.
// - No pulses before first counter overflow.
// - Compare registers are master/slave; slave compared.
// - Sine compare equal raises sine match.
// - Cosine compare equal raises cosine match.
// - Bit 4 of compare control gates rewrites.
// - Reset clears compare registers and hardware state.
// - Bits 2,3 enable alternate one-count addition.
// - Addition yields 8+1 bit precision.
// - Duty equals compare value over 255.
// - Eight channels, sine and cosine per meter.
// - H bridge pairs; half-bridge spares are ports.
// - Counter control is 8-bit, reset 00H.
// - Bit 5 clock select, bit 4 run.
package mpd_pkg;

    // Register indices; each register takes one word, byte address is four times this.
    localparam logic [4:0] MPD_IDX_CMP_BASE = 5'h00;  // 0..7: meter n sine at 2n, cosine at 2n+1.
    localparam logic [4:0] MPD_IDX_CMPC_BASE = 5'h08; // 8..11: compare control per meter.
    localparam logic [4:0] MPD_IDX_CNTC = 5'h0C;
    localparam logic [4:0] MPD_IDX_CNT = 5'h0D;       // Read-only counter view.
    localparam logic [4:0] MPD_IDX_PORT = 5'h0E;      // Port data for spare pins.
    localparam logic [4:0] MPD_IDX_PMODE = 5'h0F;     // Port mode control per pin.

    // Field positions.
    localparam int MPD_CNTC_CLKSEL_BIT = 5;
    localparam int MPD_CNTC_RUN_BIT = 4;
    localparam int MPD_CMPC_WEN_BIT = 4;
    localparam int MPD_CMPC_ADD_COS_BIT = 3;
    localparam int MPD_CMPC_ADD_SIN_BIT = 2;

    // Reset values and masks.
    localparam logic [7:0] MPD_CNTC_RST = 8'h00;
    localparam logic [7:0] MPD_CNTC_MASK = 8'h30;
    localparam logic [7:0] MPD_CMPC_MASK = 8'h1C;
    localparam logic [7:0] MPD_CMP_RST = 8'h00;
    localparam logic [7:0] MPD_CNT_START = 8'h00;
    localparam logic [7:0] MPD_CNT_WRAP = 8'h01;
    localparam logic [7:0] MPD_CNT_TOP = 8'hFF;

    // Count clock divider: select 0 counts every clock, select 1 every second clock.
    localparam logic [0:0] MPD_DIV_SLOW = 1'h1;

    // Counter state.
    typedef enum logic [1:0] {
        MPD_ST_IDLE = 2'b00,
        MPD_ST_FIRST = 2'b01,
        MPD_ST_RUN = 2'b10
    } mpd_state_t;

endpackage

//--- verilog/mpd_meter_pwm.sv
// Meter PWM driver: shared counter, eight double-buffered compare channels,
// half-step addition and port fallback for the drive pins.
// Assumes a synchronous register port; reads answer one cycle later.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
module mpd_meter_pwm
    import mpd_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic [7:0] o_meter_drive_output,
    output logic [7:0] o_match
);

    ////////////////////////////////////////////////////////////////////////////
    // Software registers.

    logic [7:0] cntc_reg;
    logic [7:0] cmpc_reg [4];
    logic [7:0] master_reg [8];
    logic [7:0] slave_reg [8];
    logic [7:0] port_reg;
    logic [7:0] pmode_reg;
    logic [7:0] cnt_reg;
    logic div_reg;
    logic [7:0] half_reg;
    logic [7:0] pwm_reg;
    mpd_state_t state_reg;
    logic tick;
    logic ovf;
    logic run;

    assign run = cntc_reg[MPD_CNTC_RUN_BIT];

    // Control register writes; only the documented bits are kept.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            cntc_reg <= MPD_CNTC_RST;
            port_reg <= 8'h00;
            pmode_reg <= 8'h00;
        end else if (i_wr) begin
            if (i_addr == MPD_IDX_CNTC) begin
                cntc_reg <= i_wdata & MPD_CNTC_MASK;
            end
            if (i_addr == MPD_IDX_PORT) begin
                port_reg <= i_wdata;
            end
            if (i_addr == MPD_IDX_PMODE) begin
                pmode_reg <= i_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count clock and counter.

    // The slow select halves the count rate with a one-bit prescaler.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst || !run) begin
            div_reg <= 1'b0;
        end else begin
            div_reg <= ~div_reg;
        end
    end

    assign tick = run && (!cntc_reg[MPD_CNTC_CLKSEL_BIT] || (div_reg == MPD_DIV_SLOW));
    assign ovf = tick && (cnt_reg == MPD_CNT_TOP);

    // Counter starts at 00H only once; after the first wrap it skips 00H, so a
    // period is 255 counts and a compare of 255 keeps the output fully on.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst || !run) begin
            cnt_reg <= MPD_CNT_START;
        end else if (ovf) begin
            cnt_reg <= MPD_CNT_WRAP;
        end else if (tick) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // Tracks whether the first overflow has been seen since the start.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst || !run) begin
            state_reg <= MPD_ST_IDLE;
        end else begin
            case (state_reg)
                MPD_ST_IDLE: begin
                    state_reg <= MPD_ST_FIRST;
                end
                MPD_ST_FIRST: begin
                    if (ovf) begin
                        state_reg <= MPD_ST_RUN;
                    end
                end
                MPD_ST_RUN: begin
                    state_reg <= MPD_ST_RUN;
                end
                default: begin
                    state_reg <= MPD_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel compare, half-step and drive logic.

    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++) begin : g_ch
            localparam int MTR = ch / 2;
            localparam int ADD_BIT = (ch % 2 == 0) ? MPD_CMPC_ADD_SIN_BIT : MPD_CMPC_ADD_COS_BIT;
            logic wen;
            logic add_en;
            logic hit;
            assign wen = cmpc_reg[MTR][MPD_CMPC_WEN_BIT];
            assign add_en = cmpc_reg[MTR][ADD_BIT];

            // Master takes software writes while its meter's write enable is set.
            always_ff @(posedge i_clk_sys) begin
                if (!i_nrst) begin
                    master_reg[ch] <= MPD_CMP_RST;
                end else if (i_wr && i_addr == MPD_IDX_CMP_BASE + 5'(ch) && wen) begin
                    master_reg[ch] <= i_wdata;
                end
            end

            // Slave loads from master on overflow only, so a half-written pair
            // never reaches the pins mid-period.
            always_ff @(posedge i_clk_sys) begin
                if (!i_nrst) begin
                    slave_reg[ch] <= MPD_CMP_RST;
                end else if (ovf && wen) begin
                    slave_reg[ch] <= master_reg[ch];
                end
            end

            // Half-step phase toggles per overflow; on odd periods the match
            // moves one count later, averaging to the half step.
            always_ff @(posedge i_clk_sys) begin
                if (!i_nrst || !run || !add_en) begin
                    half_reg[ch] <= 1'b0;
                end else if (ovf) begin
                    half_reg[ch] <= ~half_reg[ch];
                end
            end

            // Sine channels are even, cosine channels odd.
            assign hit = (cnt_reg == slave_reg[ch] + 8'(half_reg[ch]));

            always_ff @(posedge i_clk_sys) begin
                if (!i_nrst) begin
                    o_match[ch] <= 1'b0;
                end else begin
                    o_match[ch] <= run && hit;
                end
            end

            // Output rises at overflow unless the old slave is zero and no nonzero master is loaded; it falls at match.
            always_ff @(posedge i_clk_sys) begin
                if (!i_nrst || state_reg != MPD_ST_RUN && !ovf) begin
                    pwm_reg[ch] <= 1'b0;
                end else if (ovf) begin
                    pwm_reg[ch] <= (slave_reg[ch] != 8'h00) || (wen && master_reg[ch] != 8'h00)
                        ? 1'b1 : 1'b0;
                end else if (tick && hit) begin
                    pwm_reg[ch] <= 1'b0;
                end
            end

            // Pins with their port mode bit set act as plain output port pins.
            always_ff @(posedge i_clk_sys) begin
                if (!i_nrst) begin
                    o_meter_drive_output[ch] <= 1'b0;
                end else begin
                    o_meter_drive_output[ch] <= pmode_reg[ch] ? port_reg[ch] : pwm_reg[ch];
                end
            end
        end
    endgenerate

    // Compare control registers per meter.
    genvar mt;
    generate
        for (mt = 0; mt < 4; mt++) begin : g_mt
            always_ff @(posedge i_clk_sys) begin
                if (!i_nrst) begin
                    cmpc_reg[mt] <= 8'h00;
                end else if (i_wr && i_addr == MPD_IDX_CMPC_BASE + 5'(mt)) begin
                    cmpc_reg[mt] <= i_wdata & MPD_CMPC_MASK;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read zero.

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (i_addr < MPD_IDX_CMPC_BASE) begin
                o_rdata <= master_reg[i_addr[2:0]];
            end else if (i_addr < MPD_IDX_CNTC) begin
                o_rdata <= cmpc_reg[i_addr[1:0]];
            end else if (i_addr == MPD_IDX_CNTC) begin
                o_rdata <= cntc_reg;
            end else if (i_addr == MPD_IDX_CNT) begin
                o_rdata <= cnt_reg;
            end else if (i_addr == MPD_IDX_PORT) begin
                o_rdata <= port_reg;
            end else if (i_addr == MPD_IDX_PMODE) begin
                o_rdata <= pmode_reg;
            end else begin
                o_rdata <= 8'h00;
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule // mpd_meter_pwm

//--- sim/mpd_meter_pwm_sva.sv
// Checker for the meter PWM driver register port, counter and match lines.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module mpd_meter_pwm_sva
    import mpd_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_meter_drive_output,
    input wire logic [7:0] o_match
);
    logic run_reg;
    logic slow_reg;
    logic [9:0] age_reg;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////////////
    // Track run and select bits; the age lets the counter settle after a change.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            run_reg <= 1'b0;
            slow_reg <= 1'b0;
            age_reg <= 10'h000;
        end else if (i_wr && i_addr == MPD_IDX_CNTC) begin
            run_reg <= i_wdata[MPD_CNTC_RUN_BIT];
            slow_reg <= i_wdata[MPD_CNTC_CLKSEL_BIT];
            age_reg <= 10'h000;
        end else if (age_reg != 10'h3FF) begin
            age_reg <= age_reg + 10'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_wr(logic [4:0] a);
        i_wr && i_addr == a;
    endsequence
    sequence s_rd(logic [4:0] a);
        i_rd && i_addr == a;
    endsequence
    a_cntc_write_back: assert property (s_wr(MPD_IDX_CNTC) ##1 s_rd(MPD_IDX_CNTC) |=>
        o_rdata == ($past(i_wdata, 2) & MPD_CNTC_MASK)) else $error("control readback wrong");
    a_cntc_zero_bits: assert property (s_rd(MPD_IDX_CNTC) |=>
        (o_rdata & ~MPD_CNTC_MASK) == 8'h00) else $error("control spare bits set");
    a_cmpc_zero_bits: assert property (i_rd && i_addr[4:2] == 3'b010 |=>
        (o_rdata & ~MPD_CMPC_MASK) == 8'h00) else $error("compare control spare bits set");
    a_reset_clear: assert property ($rose(i_nrst) |->
        o_meter_drive_output == 8'h00 && o_match == 8'h00) else $error("outputs not cleared");
    a_stop_count: assert property (!run_reg && age_reg > 10'h002 && i_rd && i_addr == MPD_IDX_CNT
        |=> o_rdata == 8'h00) else $error("stopped counter not zero");
    a_run_nonzero: assert property (run_reg && age_reg > 10'h258 && i_rd && i_addr == MPD_IDX_CNT
        |=> o_rdata != 8'h00) else $error("running counter read zero");
    a_stop_match: assert property (i_wr && i_addr == MPD_IDX_CNTC && !i_wdata[MPD_CNTC_RUN_BIT]
        |-> ##3 o_match == 8'h00) else $error("match while stopped");
    a_match_moves: assert property (run_reg && !slow_reg && age_reg > 10'h258 && o_match != 8'h00
        |=> o_match != $past(o_match)) else $error("match held two ticks");
endmodule // mpd_meter_pwm_sva

//--- sim/mpd_coil_model.sv
// Coil model: integrates the on-time of each drive pin as coil current.
// Assumes the pins are sampled on the system clock; clear opens a window.
`timescale 1ns/1ns
module mpd_coil_model (
    input wire logic i_clk_sys,
    input wire logic i_clr,
    input wire logic [7:0] i_drive,
    output int o_on[8]
);
    // Each pin adds one per cycle at the high rail, as an H or half bridge would.
    always @(posedge i_clk_sys) begin
        for (int k = 0; k < 8; k++) begin
            o_on[k] <= i_clr ? 0 : o_on[k] + int'(i_drive[k]);
        end
    end
endmodule // mpd_coil_model

//--- sim/tb_top.sv
// Testbench for the meter PWM driver with a register model and coil model.
// Assumes one 25 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ns
module tb_top;
    import mpd_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic [7:0] o_meter_drive_output;
    logic [7:0] o_match;
    logic [7:0] q;
    logic clr = 1'b1;
    int on[8];
    int exp_reg[32];
    int v[4];
    int m0;
    int m3;
    int failures = 0;
    int compares = 0;
    int seed = 32'h0000_e79f;
    mpd_meter_pwm uut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_meter_drive_output(o_meter_drive_output), .o_match(o_match));
    mpd_coil_model coil (.i_clk_sys(i_clk_sys), .i_clr(clr), .i_drive(o_meter_drive_output),
        .o_on(on));
    ////////////////////////////////////////////////////////////////////////
    // Free-running 40 ns clock.
    always #20 i_clk_sys = ~i_clk_sys;
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %0h seen %0h", name, exp, seen);
        end
    endtask
    // Writes are single bytes; the model drops compare writes while rewrite is off.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        i_rd <= 1'b0;
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        if (a < 5'h08 && exp_reg[8 + a / 2][MPD_CMPC_WEN_BIT]) exp_reg[a] = d;
        if (a[4:2] == 3'b010) exp_reg[a] = d & MPD_CMPC_MASK;
        if (a == MPD_IDX_CNTC) exp_reg[a] = d & MPD_CNTC_MASK;
    endtask
    task automatic rd(input logic [4:0] a);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        #1 q = o_rdata;
    endtask
    task automatic idle(input int n);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (n) @(posedge i_clk_sys);
    endtask
    // A window spanning whole periods gives exact on-time whatever its phase.
    task automatic win(input int n);
        clr <= 1'b1;
        idle(1);
        clr <= 1'b0;
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic print_verdict();
        if (failures == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: under four times the expected run length.
    initial begin
        #1000000;
        failures++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        for (int a = 0; a < 32; a++) begin
            rd(a[4:0]);
            chk("reg", q, exp_reg[a]);
        end
        wr(5'h04, 8'h55);
        wr(5'h08, 8'h10);
        wr(5'h09, 8'h1C);
        for (int k = 0; k < 4; k++) begin
            v[k] = (k == 1) ? 0 : 1 + $unsigned($random(seed)) % 254;
            wr(k[4:0], v[k][7:0]);
        end
        for (int a = 0; a < 12; a++) begin
            rd(a[4:0]);
            chk("reg", q, exp_reg[a]);
        end
        wr(MPD_IDX_CNTC, 8'hFF);
        rd(MPD_IDX_CNTC);
        chk("cntc", q, exp_reg[MPD_IDX_CNTC]);
        repeat (500) @(negedge i_clk_sys) chk("drive", o_meter_drive_output, 8'h00);
        @(posedge i_clk_sys);
        for (int f = 2; f > 0; f--) begin
            idle(1200);
            win(1020 * f);
            for (int k = 0; k < 4; k++) begin
                chk("on", on[k], k < 2 ? 4 * f * v[k] : 2 * f * (2 * v[k] + 1));
            end
            chk("on", on[4], 0);
            // One match per period; a slow tick holds the match for two clocks.
            m0 = 0;
            m3 = 0;
            repeat (255 * f) @(negedge i_clk_sys) begin
                m0 += int'(o_match[0]);
                m3 += int'(o_match[3]);
            end
            chk("match0", m0, f);
            chk("match3", m3, f);
            rd(MPD_IDX_CNT);
            chk("count", q == 8'h00, 1'b0);
            wr(MPD_IDX_CNTC, 8'h10);
        end
        wr(MPD_IDX_CNTC, 8'h00);
        idle(4);
        rd(MPD_IDX_CNT);
        chk("count", q, 8'h00);
        wr(MPD_IDX_PORT, 8'hA5);
        wr(MPD_IDX_PMODE, 8'hFF);
        idle(3);
        rd(MPD_IDX_CNTC);
        chk("drive", o_meter_drive_output, 8'hA5);
        print_verdict();
    end
endmodule // tb_top
bind mpd_meter_pwm mpd_meter_pwm_sva chk_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_meter_drive_output(o_meter_drive_output), .o_match(o_match));
